// *** rtl/tfh_pkg.sv ***
// constants, types and register map of the touch frequency hop block
// assumes one clock domain and a front end that delivers one sample per node per cycle
package tfh_pkg;
    localparam int TFH_DW = 16;
    localparam int TFH_NSENS = 4;
    localparam int TFH_NSLOT = 3;
    localparam int TFH_NCODE = 16;
    localparam int TFH_AW = 8;

    // register byte offsets
    localparam logic [7:0] TFH_OFS_CTRL = 8'h00;
    localparam logic [7:0] TFH_OFS_LIMIT = 8'h04;
    localparam logic [7:0] TFH_OFS_INITF = 8'h08;
    localparam logic [7:0] TFH_OFS_STATUS = 8'h0c;
    localparam logic [7:0] TFH_OFS_HOPSET = 8'h10;
    localparam logic [7:0] TFH_OFS_RESULT = 8'h20;

    // field positions
    localparam int TFH_CTRL_EN_BIT = 0;
    localparam int TFH_CTRL_CNT_LSB = 4;
    localparam int TFH_LIMIT_VAR_LSB = 0;
    localparam int TFH_LIMIT_NEED_LSB = 8;
    localparam int TFH_STAT_FREQ_LSB = 0;
    localparam int TFH_STAT_SLOT_LSB = 4;
    localparam int TFH_STAT_HOP_LSB = 8;

    // reset values
    localparam logic [31:0] TFH_CTRL_RST = 32'h0000_0040;
    localparam logic [31:0] TFH_LIMIT_RST = 32'h0000_0320;
    localparam logic [31:0] TFH_INITF_RST = 32'h0000_0a62;
    localparam logic [7:0] TFH_HOP_STATUS = 8'h00;

    localparam logic [1:0] TFH_RESP_OKAY = 2'b00;
    localparam logic [1:0] TFH_RESP_SLVERR = 2'b10;

    typedef enum logic {TFH_PH_COLLECT, TFH_PH_EVAL} tfh_phase_t;

    // one node sample from the acquisition front end
    typedef struct packed {
        logic valid;
        logic [1:0] node;
        logic [TFH_DW-1:0] data;
    } tfh_sample_t;
endpackage

// *** rtl/tfh_median3.sv ***
// three point median of unsigned samples
// assumes the caller registers the result
`timescale 1ns/1ps
module tfh_median3 #(
    parameter int W = 16
) (
    input wire logic [W-1:0] a,
    input wire logic [W-1:0] b,
    input wire logic [W-1:0] c,
    output logic [W-1:0] m
);
    // drop largest and smallest, keep the middle
    always_comb begin
        if ((a >= b && a <= c) || (a <= b && a >= c)) begin
            m = a;
        end else if ((b >= a && b <= c) || (b <= a && b >= c)) begin
            m = b;
        end else begin
            m = c;
        end
    end
endmodule

// *** rtl/tfh_hop_top.sv ***
// frequency hop sequencer with median filter and noise driven auto-tune
// assumes front end samples on aclk: burst code out, samples and cycle_end in
//
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
module tfh_hop_top
    import tfh_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [TFH_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [TFH_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire tfh_sample_t sample,
    input wire logic cycle_end,
    output logic [3:0] burst_frequency_select,
    output logic [TFH_NSENS*TFH_DW-1:0] median_out,
    output logic median_valid
);

    ////////////////////////////////////////////////////////////////////////
    // register bus

    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [TFH_AW-1:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d, awready_q, awready_d, wready_q, wready_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d, arready_q, arready_d;
    logic [1:0] rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] ctrl_q, ctrl_d, limit_q, limit_d, initf_q, initf_d;
    logic initf_wr_q, initf_wr_d;
    logic [31:0] rd_word;
    logic rd_ok;

    // pipeline state declared early for status reads
    tfh_phase_t phase_q, phase_d;
    logic [1:0] slot_q, slot_d;
    logic [3:0] freq_q [TFH_NSLOT];
    logic [3:0] freq_d [TFH_NSLOT];
    logic [TFH_DW-1:0] res_q [TFH_NSENS];
    logic [TFH_DW-1:0] res_d [TFH_NSENS];
    logic [3:0] bfs_q, bfs_d;

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = n[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // read decode
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        if (s_axi_araddr == TFH_OFS_CTRL) begin
            rd_word = ctrl_q;
        end else if (s_axi_araddr == TFH_OFS_LIMIT) begin
            rd_word = limit_q;
        end else if (s_axi_araddr == TFH_OFS_INITF) begin
            rd_word = initf_q;
        end else if (s_axi_araddr == TFH_OFS_STATUS) begin
            rd_word[TFH_STAT_FREQ_LSB +: 4] = bfs_q;
            rd_word[TFH_STAT_SLOT_LSB +: 2] = slot_q;
            rd_word[TFH_STAT_HOP_LSB +: 8] = TFH_HOP_STATUS;
        end else if (s_axi_araddr == TFH_OFS_HOPSET) begin
            rd_word[11:0] = {freq_q[2], freq_q[1], freq_q[0]};
        end else if (s_axi_araddr >= TFH_OFS_RESULT && s_axi_araddr < TFH_OFS_RESULT + 8'h10
                     && s_axi_araddr[1:0] == 2'b00) begin
            rd_word[TFH_DW-1:0] = res_q[s_axi_araddr[3:2]];
        end else begin
            rd_ok = 1'b0;
        end
    end

    // write channel capture in either order, one response after both
    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        ctrl_d = ctrl_q;
        limit_d = limit_q;
        initf_d = initf_q;
        // seed write request held until an evaluation consumes it, a new write wins
        initf_wr_d = initf_wr_q;
        if (phase_q == TFH_PH_EVAL) begin
            initf_wr_d = 1'b0;
        end
        if (s_axi_awvalid && awready_q) begin
            aw_have_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_have_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (aw_have_q && w_have_q && !bvalid_q) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = TFH_RESP_OKAY;
            if (awaddr_q == TFH_OFS_CTRL) begin
                ctrl_d = merge(ctrl_q, wdata_q, wstrb_q);
            end else if (awaddr_q == TFH_OFS_LIMIT) begin
                limit_d = merge(limit_q, wdata_q, wstrb_q);
            end else if (awaddr_q == TFH_OFS_INITF) begin
                initf_d = merge(initf_q, wdata_q, wstrb_q);
                initf_wr_d = 1'b1;
            end else if (awaddr_q == TFH_OFS_STATUS || awaddr_q == TFH_OFS_HOPSET
                         || (awaddr_q >= TFH_OFS_RESULT && awaddr_q < TFH_OFS_RESULT + 8'h10)) begin
                bresp_d = TFH_RESP_OKAY; // read-only, write ignored
            end else begin
                bresp_d = TFH_RESP_SLVERR;
            end
        end
        // ready registered so the port comes from a flop
        awready_d = !aw_have_d;
        wready_d = !w_have_d;
    end

    // read channel, data one cycle after the address is taken
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rdata_d = rd_word;
            rresp_d = rd_ok ? TFH_RESP_OKAY : TFH_RESP_SLVERR;
        end
        arready_d = !rvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= TFH_RESP_OKAY;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= TFH_RESP_OKAY;
            arready_q <= 1'b0;
            ctrl_q <= TFH_CTRL_RST;
            limit_q <= TFH_LIMIT_RST;
            initf_q <= TFH_INITF_RST;
            initf_wr_q <= 1'b0;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            arready_q <= arready_d;
            ctrl_q <= ctrl_d;
            limit_q <= limit_d;
            initf_q <= initf_d;
            initf_wr_q <= initf_wr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration fields

    logic tune_en;
    logic [2:0] nsens_raw, nsens;
    logic [7:0] var_lim, need_cnt;

    always_comb begin
        tune_en = ctrl_q[TFH_CTRL_EN_BIT];
        nsens_raw = ctrl_q[TFH_CTRL_CNT_LSB +: 3];
        // out of range counts clamp into 1..4
        if (nsens_raw == 3'd0) begin
            nsens = 3'd1;
        end else if (nsens_raw > 3'd4) begin
            nsens = 3'd4;
        end else begin
            nsens = nsens_raw;
        end
        // a zero limit would flag every cycle, so treat it as 1
        var_lim = (limit_q[TFH_LIMIT_VAR_LSB +: 8] == 8'h00) ? 8'h01 : limit_q[TFH_LIMIT_VAR_LSB +: 8];
        need_cnt = (limit_q[TFH_LIMIT_NEED_LSB +: 8] == 8'h00) ? 8'h01 : limit_q[TFH_LIMIT_NEED_LSB +: 8];
    end

    ////////////////////////////////////////////////////////////////////////
    // median filter per sensor

    logic [TFH_DW-1:0] hist_q [TFH_NSLOT][TFH_NSENS];
    logic [TFH_DW-1:0] hist_d [TFH_NSLOT][TFH_NSENS];
    logic [TFH_DW-1:0] med [TFH_NSENS];

    genvar gs;
    generate
        for (gs = 0; gs < TFH_NSENS; gs++) begin : g_med
            tfh_median3 #(.W(TFH_DW)) u_med (
                .a(hist_q[0][gs]),
                .b(hist_q[1][gs]),
                .c(hist_q[2][gs]),
                .m(med[gs])
            );
            assign median_out[gs*TFH_DW +: TFH_DW] = res_q[gs];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // hop sequencer and auto-tune

    logic [2:0] filled_q, filled_d, primed_q, primed_d;
    logic [TFH_DW-1:0] var_q, var_d;
    logic [7:0] noisy_q [TFH_NSLOT];
    logic [7:0] noisy_d [TFH_NSLOT];
    logic [4:0] tries_q [TFH_NSLOT];
    logic [4:0] tries_d [TFH_NSLOT];
    logic [3:0] best_q [TFH_NSLOT];
    logic [3:0] best_d [TFH_NSLOT];
    logic [TFH_DW-1:0] bvar_q [TFH_NSLOT];
    logic [TFH_DW-1:0] bvar_d [TFH_NSLOT];
    logic med_valid_q, med_valid_d;
    logic [TFH_DW-1:0] delta;
    logic [1:0] nxt_slot, o1, o2;
    logic noisy;

    // next code not already held by the other two slots
    function automatic logic [3:0] next_free(input logic [3:0] cur, input logic [3:0] a, input logic [3:0] b);
        logic [3:0] c;
        c = cur + 4'h1;
        if (c == a || c == b) begin
            c = c + 4'h1;
        end
        if (c == a || c == b) begin
            c = c + 4'h1;
        end
        return c;
    endfunction

    always_comb begin
        phase_d = phase_q;
        slot_d = slot_q;
        freq_d = freq_q;
        hist_d = hist_q;
        res_d = res_q;
        bfs_d = bfs_q;
        filled_d = filled_q;
        primed_d = primed_q;
        var_d = var_q;
        noisy_d = noisy_q;
        tries_d = tries_q;
        best_d = best_q;
        bvar_d = bvar_q;
        med_valid_d = 1'b0;
        delta = '0;
        noisy = 1'b0;
        nxt_slot = (slot_q == 2'd2) ? 2'd0 : slot_q + 2'd1;
        o1 = (slot_q == 2'd0) ? 2'd1 : 2'd0;
        o2 = (slot_q == 2'd2) ? 2'd1 : 2'd2;
        case (phase_q)
            TFH_PH_COLLECT: begin
                // newest sample replaces the one taken at this frequency
                if (sample.valid && {1'b0, sample.node} < nsens) begin
                    delta = (sample.data > hist_q[slot_q][sample.node])
                        ? sample.data - hist_q[slot_q][sample.node]
                        : hist_q[slot_q][sample.node] - sample.data;
                    hist_d[slot_q][sample.node] = sample.data;
                    filled_d[slot_q] = 1'b1;
                    if (primed_q[slot_q] && delta > var_q) begin
                        var_d = delta; // worst node sets the slot variance
                    end
                end
                if (cycle_end) begin
                    phase_d = TFH_PH_EVAL;
                end
            end
            TFH_PH_EVAL: begin
                // median over the newest three, one per frequency
                if (&filled_q) begin
                    res_d = med;
                    med_valid_d = 1'b1;
                end
                primed_d[slot_q] = 1'b1;
                if (tune_en) begin
                    noisy = primed_q[slot_q] && var_q > {{(TFH_DW-8){1'b0}}, var_lim};
                    if (noisy) begin
                        noisy_d[slot_q] = noisy_q[slot_q] + 8'h01;
                        if (noisy_q[slot_q] + 8'h01 >= need_cnt) begin
                            noisy_d[slot_q] = 8'h00;
                            primed_d[slot_q] = 1'b0;
                            // remember the quietest code seen so far
                            if (var_q < bvar_q[slot_q]) begin
                                bvar_d[slot_q] = var_q;
                                best_d[slot_q] = freq_q[slot_q];
                            end
                            if (tries_q[slot_q] + 5'd1 >= 5'(TFH_NCODE)) begin
                                // every candidate noisy: settle on the quietest
                                freq_d[slot_q] = (var_q < bvar_q[slot_q]) ? freq_q[slot_q] : best_q[slot_q];
                                tries_d[slot_q] = 5'd0;
                                bvar_d[slot_q] = '1;
                            end else begin
                                // only this slot moves, the other two stay
                                freq_d[slot_q] = next_free(freq_q[slot_q], freq_q[o1], freq_q[o2]);
                                tries_d[slot_q] = tries_q[slot_q] + 5'd1;
                            end
                        end
                    end else if (primed_q[slot_q]) begin
                        // stable frequency is kept and the search resets
                        noisy_d[slot_q] = 8'h00;
                        tries_d[slot_q] = 5'd0;
                        bvar_d[slot_q] = '1;
                    end
                end
                if (initf_wr_q) begin
                    // a fresh seed write reloads the hop set
                    freq_d[0] = initf_q[3:0];
                    freq_d[1] = initf_q[7:4];
                    freq_d[2] = initf_q[11:8];
                    primed_d = 3'b000;
                end
                var_d = '0;
                slot_d = nxt_slot;
                bfs_d = freq_d[nxt_slot];
                phase_d = TFH_PH_COLLECT;
            end
            default: begin
                phase_d = TFH_PH_COLLECT;
            end
        endcase
    end

    // a seed write landing outside an evaluation is caught at the next one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_q <= TFH_PH_COLLECT;
            slot_q <= 2'd0;
            freq_q[0] <= TFH_INITF_RST[3:0];
            freq_q[1] <= TFH_INITF_RST[7:4];
            freq_q[2] <= TFH_INITF_RST[11:8];
            bfs_q <= TFH_INITF_RST[3:0];
            hist_q <= '{default: '0};
            res_q <= '{default: '0};
            filled_q <= 3'b000;
            primed_q <= 3'b000;
            var_q <= '0;
            noisy_q <= '{default: '0};
            tries_q <= '{default: '0};
            best_q <= '{default: '0};
            bvar_q <= '{default: '1};
            med_valid_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            slot_q <= slot_d;
            freq_q <= freq_d;
            bfs_q <= bfs_d;
            hist_q <= hist_d;
            res_q <= res_d;
            filled_q <= filled_d;
            primed_q <= primed_d;
            var_q <= var_d;
            noisy_q <= noisy_d;
            tries_q <= tries_d;
            best_q <= best_d;
            bvar_q <= bvar_d;
            med_valid_q <= med_valid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign burst_frequency_select = bfs_q;
    assign median_valid = med_valid_q;

endmodule

// *** tb/tfh_hop_sva.sv ***
// assertions on the ports of the hop block
// assumes it is bound onto tfh_hop_top, single clock, sync reset
`timescale 1ns/1ps
module tfh_hop_sva
    import tfh_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cycle_end,
    input wire logic [3:0] burst_frequency_select,
    input wire logic [TFH_NSENS*TFH_DW-1:0] median_out,
    input wire logic median_valid
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////
    // bus answers: write response two edges after both halves are taken, read data one
    bresp_follows_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    rresp_follows_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address open during answer");
    ////////////////////////////////////////////////////////////////
    // hop stream: code and median move only two edges after cycle end
    freq_step_a: assert property (cycle_end && !$past(cycle_end) |-> ##2 burst_frequency_select != $past(burst_frequency_select, 2))
        else $error("frequency did not step");
    freq_when_a: assert property ($changed(burst_frequency_select) |-> $past(cycle_end, 2))
        else $error("frequency changed off cycle");
    mv_when_a: assert property (median_valid |-> $past(cycle_end, 2) && !$past(median_valid))
        else $error("median pulse off cycle");
    median_hold_a: assert property (!median_valid |-> $stable(median_out))
        else $error("median moved without pulse");
endmodule

// *** tb/tfh_fe_model.sv ***
// acquisition front end model: one sample per node, then cycle end
// assumes the caller waits for the evaluation before the next cycle
`timescale 1ns/1ps
module tfh_fe_model
    import tfh_pkg::*;
(
    input wire logic aclk,
    output tfh_sample_t sample,
    output logic cycle_end
);
    initial begin
        sample <= '0;
        cycle_end <= 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // one measurement cycle; idle data inverted so stale values never match
    task automatic run(input logic [15:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge aclk);
            sample <= {1'b1, i[1:0], v};
        end
        @(posedge aclk);
        sample <= {1'b0, 2'd0, ~v};
        cycle_end <= 1'b1;
        @(posedge aclk);
        cycle_end <= 1'b0;
    endtask
endmodule

// *** tb/touch_freq_hop_median_autotune_tb_top.sv ***
// testbench of the hop block: registers, median stream, auto-tune
// assumes the front end model and the checker are compiled first
`timescale 1ns/1ps
module touch_freq_hop_median_autotune_tb_top
    import tfh_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cycle_end, median_valid;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, burst_frequency_select;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    tfh_sample_t sample;
    logic [TFH_NSENS*TFH_DW-1:0] median_out;
    int err_total = 0;
    int compares = 0;
    int cyc_n = 0;
    always #20 aclk = ~aclk;
    tfh_hop_top i_tfh_hop_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .sample(sample), .cycle_end(cycle_end),
        .burst_frequency_select(burst_frequency_select), .median_out(median_out), .median_valid(median_valid));
    tfh_fe_model i_tfh_fe_model (.aclk(aclk), .sample(sample), .cycle_end(cycle_end));
    ////////////////////////////////////////////////////////////////
    // compare, verdict and hang limit
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // whole run is about 160 cycles, so this only trips on a hang
    always @(posedge aclk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 5000) begin
            err_total++;
            end_of_test;
        end
    end
    ////////////////////////////////////////////////////////////////
    // bus master: ready-to-accept raised late so hold paths are exercised
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b0;
        do begin
            @(posedge aclk);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        chk(s_axi_bresp, er);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [33:0] exp);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b0;
        do begin
            @(posedge aclk);
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        chk({s_axi_rresp, s_axi_rdata}, exp);
    endtask
    // one cycle, then look at code and pulse after the evaluation edge
    task automatic meas(input logic [15:0] v, input int n, input logic [3:0] ef, input logic ev);
        i_tfh_fe_model.run(v, n);
        // the pulse stands for one cycle only
        @(posedge aclk);
        #1;
        chk({burst_frequency_select, median_valid}, {ef, ev});
    endtask
    task automatic do_reset;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    ////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset;
        chk(burst_frequency_select, 4'h2);
        rdchk(TFH_OFS_CTRL, {2'b00, TFH_CTRL_RST});
        rdchk(TFH_OFS_LIMIT, {2'b00, TFH_LIMIT_RST});
        rdchk(TFH_OFS_INITF, {2'b00, 32'h0000_0a62});
        rdchk(TFH_OFS_STATUS, {2'b00, 32'h0000_0002});
        rdchk(8'h14, {TFH_RESP_SLVERR, 32'h0});
        wr(8'h14, 32'h1, TFH_RESP_SLVERR);
        wr(TFH_OFS_HOPSET, 32'h0, TFH_RESP_OKAY);
        rdchk(TFH_OFS_HOPSET, {2'b00, 32'h0000_0a62});
    endtask
    task automatic t_median;
        meas(16'd30, 4, 4'h6, 1'b0);
        meas(16'd10, 4, 4'ha, 1'b0);
        meas(16'd20, 4, 4'h2, 1'b1);
        chk(median_out, {4{16'd20}});
        meas(16'd5, 4, 4'h6, 1'b1);
        chk(median_out, {4{16'd10}});
        rdchk(TFH_OFS_RESULT + 8'h0c, {2'b00, 32'd10});
        rdchk(TFH_OFS_STATUS, {2'b00, 32'h0000_0016});
    endtask
    task automatic t_tune;
        logic [3:0] seq [3];
        seq = '{4'h6, 4'ha, 4'h2};
        wr(TFH_OFS_CTRL, 32'h0000_0011, TFH_RESP_OKAY);
        wr(TFH_OFS_LIMIT, 32'h0000_0104, TFH_RESP_OKAY);
        for (int i = 0; i < 6; i++) begin
            meas(16'd100, 1, seq[i % 3], i >= 2);
        end
        meas(16'd300, 1, 4'h6, 1'b1);
        meas(16'd100, 1, 4'ha, 1'b1);
        meas(16'd100, 1, 4'h3, 1'b1);
        rdchk(TFH_OFS_HOPSET, {2'b00, 32'h0000_0a63});
        rdchk(TFH_OFS_STATUS, {2'b00, 32'h0000_0003});
        // seed write during collect, reloaded at the next evaluation
        wr(TFH_OFS_INITF, 32'h0000_0954, TFH_RESP_OKAY);
        meas(16'd100, 1, 4'h5, 1'b1);
        rdchk(TFH_OFS_HOPSET, {2'b00, 32'h0000_0954});
    endtask
    initial begin
        aresetn <= 1'b0;
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_arvalid <= 1'b0;
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        s_axi_awaddr <= 8'h00;
        s_axi_araddr <= 8'h00;
        s_axi_wdata <= 32'h0;
        s_axi_wstrb <= 4'hf;
        do_reset;
        t_reset;
        t_median;
        do_reset;
        t_tune;
        end_of_test;
    end
endmodule
bind tfh_hop_top tfh_hop_sva i_tfh_hop_sva (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .cycle_end(cycle_end),
    .burst_frequency_select(burst_frequency_select), .median_out(median_out), .median_valid(median_valid));
